// ---- design/oos_seq_pkg.sv ----
// constants, register map and state encoding of the out-of-step trip sequencer
// assumes one processing clock mclk at 20 MHz and a synchronous reset
package oos_seq_pkg;

	// bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int TIMER_W = 16;

	// clock and timer tick: every delay setting counts in ticks of one ms
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_TIME_NS = 1000000;
	localparam int TICK_CYCLES_DEF = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_PICKUP1 = 8'h04;
	localparam logic [ADDR_W-1:0] REG_RESET1 = 8'h08;
	localparam logic [ADDR_W-1:0] REG_PICKUP2 = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_PICKUP3 = 8'h10;
	localparam logic [ADDR_W-1:0] REG_PICKUP4 = 8'h14;
	localparam logic [ADDR_W-1:0] REG_SEALIN = 8'h18;
	localparam logic [ADDR_W-1:0] REG_SUPV = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;

	// control register fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_THREESTEP_BIT = 1;
	localparam int CTRL_LENS_BIT = 2;
	localparam int CTRL_DELAYED_BIT = 3;
	localparam int CTRL_W = 4;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [TIMER_W-1:0] DELAY_RST = 16'h0001;
	localparam logic [TIMER_W-1:0] SUPV_RST = 16'h0000;

	// zone index inside three-bit zone vectors
	localparam int ZONE_OUTER = 0;
	localparam int ZONE_MIDDLE = 1;
	localparam int ZONE_INNER = 2;
	localparam int NUM_ZONES = 3;

	// out-of-step sequence states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_LATCH1 = 5'h02,
		ST_LATCH2 = 5'h04,
		ST_ARMED = 5'h08,
		ST_LATCH4 = 5'h10
	} seq_state_type;

endpackage : oos_seq_pkg

// ---- design/out_of_step_trip_sequencer.sv ----
// out-of-step trip sequencer: swing blocking latch, trip sequence, seal-in and register port
// assumes zone comparators, disturbance detector and block input run on mclk
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module out_of_step_trip_sequencer #(
	parameter int TICK_CYCLES = oos_seq_pkg::TICK_CYCLES_DEF, // clock cycles per timer tick
	parameter int TW          = oos_seq_pkg::TIMER_W          // width of delay settings
) (
	input  wire logic                            mclk,
	input  wire logic                            rst,
	input  wire logic [oos_seq_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [oos_seq_pkg::DATA_W-1:0]  regWdata,
	input  wire logic                            regWr,
	input  wire logic                            regRd,
	output logic [oos_seq_pkg::DATA_W-1:0]       regRdata,
	input  wire logic [oos_seq_pkg::TIMER_W-1:0] posSeqCurrent,
	input  wire logic [2:0]                      lensZone,
	input  wire logic [2:0]                      rectZone,
	input  wire logic [2:0]                      rightBlinder,
	input  wire logic [2:0]                      leftBlinder,
	input  wire logic                            disturbRaw,
	input  wire logic                            trip_block_input,
	output logic                                 outerZone,
	output logic                                 middleZone,
	output logic                                 innerZone,
	output logic                                 timer2_pickup_flag,
	output logic                                 timer3_pickup_flag,
	output logic                                 timer4_pickup_flag,
	output logic                                 swingBlockOut,
	output logic                                 swing_unblockable_out,
	output logic                                 disturbance_detect_out,
	output logic                                 incomingOut,
	output logic                                 outgoingOut,
	output logic                                 tripOut
);
	import oos_seq_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	logic [CTRL_W-1:0]  ctrl_r;              // enable, mode, shape, trip mode
	logic [TW-1:0]      pickup1_r;           // first pickup delay, ticks
	logic [TW-1:0]      reset1_r;            // blocking dropout delay, ticks
	logic [TW-1:0]      pickup2_r;           // middle-zone pickup delay
	logic [TW-1:0]      pickup3_r;           // inner-zone pickup delay
	logic [TW-1:0]      pickup4_r;           // delayed-mode pickup delay
	logic [TW-1:0]      trip_sealin_time;    // trip seal-in length, ticks
	logic [TIMER_W-1:0] current_supervision_level; // supervision pickup
	logic               enable;              // whole element on
	logic               threeStep;           // three-step versus two-step
	logic               lensShape;           // lens versus rectangular
	logic               tripDelayed;         // delayed versus early trip
	logic [2:0]         zone;                // qualified zone flags
	logic               outer;               // locus inside outer zone
	logic               middle;              // locus inside middle zone
	logic               inner;               // locus inside inner zone
	logic [31:0]        tickCnt_r;           // prescaler for the ms tick
	logic               tick;                // one-cycle timer tick
	seq_state_type      state_r;             // trip sequence state
	seq_state_type      state_nxt;           // its next value
	logic               tmr1Run;             // first timer condition
	logic               tmr2Run;             // second timer condition
	logic               tmr3Run;             // third timer condition
	logic               tmr4Run;             // fourth timer condition
	logic               rst1Run;             // reset timer condition
	logic               tmr1Done;            // first timer expired
	logic               tmr2Done;            // second timer expired
	logic               tmr3Done;            // third timer expired
	logic               tmr4Done;            // fourth timer expired
	logic               rst1Done;            // reset timer expired
	logic               seqClr;              // clear sequence, tick, latches and outputs, not settings
	logic               blockLatch_r;        // swing blocking latch
	logic               faultSeen_r;         // fault after blocking set
	logic               tripEvent;           // one-cycle trip initiation
	logic               incomingEvent;       // unstable swing entering inner
	logic               outgoingEvent;       // unstable swing leaving outer
	logic [TW-1:0]      sealCnt_r;           // seal-in ticks remaining
	logic               sealLive_r;          // seal-in interval running

	assign enable      = ctrl_r[CTRL_ENABLE_BIT];
	assign threeStep   = ctrl_r[CTRL_THREESTEP_BIT];
	assign lensShape   = ctrl_r[CTRL_LENS_BIT];
	assign tripDelayed = ctrl_r[CTRL_DELAYED_BIT];
	assign seqClr      = rst || !enable;

	////////////////////////////////////////////////////////////////////////////////
	// register port

	// settings writes; a write to status or a hole is dropped silently
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_r                    <= CTRL_RST;
			pickup1_r                 <= DELAY_RST;
			reset1_r                  <= DELAY_RST;
			pickup2_r                 <= DELAY_RST;
			pickup3_r                 <= DELAY_RST;
			pickup4_r                 <= DELAY_RST;
			trip_sealin_time          <= DELAY_RST;
			current_supervision_level <= SUPV_RST;
		end else if (regWr) begin
			case (regAddr)
				REG_CTRL:    ctrl_r <= regWdata[CTRL_W-1:0];
				REG_PICKUP1: pickup1_r <= regWdata[TW-1:0];
				REG_RESET1:  reset1_r <= regWdata[TW-1:0];
				REG_PICKUP2: pickup2_r <= regWdata[TW-1:0];
				REG_PICKUP3: pickup3_r <= regWdata[TW-1:0];
				REG_PICKUP4: pickup4_r <= regWdata[TW-1:0];
				REG_SEALIN:  trip_sealin_time <= regWdata[TW-1:0];
				REG_SUPV:    current_supervision_level <= regWdata[TIMER_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// read data one cycle after the strobe, zero otherwise and for holes
	always_ff @(posedge mclk) begin
		if (rst || !regRd) begin
			regRdata <= '0;
		end else begin
			case (regAddr)
				REG_CTRL:    regRdata <= DATA_W'(ctrl_r);
				REG_PICKUP1: regRdata <= DATA_W'(pickup1_r);
				REG_RESET1:  regRdata <= DATA_W'(reset1_r);
				REG_PICKUP2: regRdata <= DATA_W'(pickup2_r);
				REG_PICKUP3: regRdata <= DATA_W'(pickup3_r);
				REG_PICKUP4: regRdata <= DATA_W'(pickup4_r);
				REG_SEALIN:  regRdata <= DATA_W'(trip_sealin_time);
				REG_SUPV:    regRdata <= DATA_W'(current_supervision_level);
				// live state: sequence state, zone flags, blocking latch, unblockable, disturbance and trip flags
				REG_STATUS:  regRdata <= DATA_W'({state_r, zone, blockLatch_r,
					swing_unblockable_out, disturbance_detect_out, tripOut});
				default:     regRdata <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// zones and tick

	zone_qualifier #(
		.NZ(NUM_ZONES)
	) u_zone (
		.mclk                      (mclk),
		.rst                       (rst),
		.enable                    (enable),
		.lensShape                 (lensShape),
		.posSeqCurrent             (posSeqCurrent),
		.current_supervision_level (current_supervision_level),
		.lensZone                  (lensZone),
		.rectZone                  (rectZone),
		.rightBlinder              (rightBlinder),
		.leftBlinder               (leftBlinder),
		.zone                      (zone)
	);

	assign outer  = zone[ZONE_OUTER];
	assign middle = zone[ZONE_MIDDLE];
	assign inner  = zone[ZONE_INNER];

	// shared ms tick; timers therefore resolve to one tick, not one cycle
	always_ff @(posedge mclk) begin
		if (seqClr || tickCnt_r == 32'(TICK_CYCLES - 1)) begin
			tickCnt_r <= '0;
		end else begin
			tickCnt_r <= tickCnt_r + 32'h00000001;
		end
	end
	assign tick = !seqClr && (tickCnt_r == 32'(TICK_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////////////
	// timers

	// first stage: outer-middle band, or outer-inner band in two-step
	assign tmr1Run = !seqClr && outer &&
		!(threeStep ? middle : inner);
	// second stage only exists in three-step
	assign tmr2Run = !seqClr && threeStep && state_r == ST_LATCH1
		&& middle && !inner;
	// inner stage follows latch two, or latch one directly in two-step
	assign tmr3Run = !seqClr && inner && (state_r == ST_LATCH2 ||
		(!threeStep && state_r == ST_LATCH1));
	// delayed mode: time spent back outside inner but within outer
	assign tmr4Run = !seqClr && tripDelayed && state_r == ST_ARMED
		&& outer && !inner;
	// blocking dropout starts once the locus leaves outer
	assign rst1Run = !seqClr && blockLatch_r && !outer;

	pickup_timer #(.TW(TW)) u_tmr1 (
		.mclk(mclk), .rst(rst), .run(tmr1Run), .tick(tick), .preset(pickup1_r), .done(tmr1Done)
	);
	pickup_timer #(.TW(TW)) u_tmr2 (
		.mclk(mclk), .rst(rst), .run(tmr2Run), .tick(tick), .preset(pickup2_r), .done(tmr2Done)
	);
	pickup_timer #(.TW(TW)) u_tmr3 (
		.mclk(mclk), .rst(rst), .run(tmr3Run), .tick(tick), .preset(pickup3_r), .done(tmr3Done)
	);
	pickup_timer #(.TW(TW)) u_tmr4 (
		.mclk(mclk), .rst(rst), .run(tmr4Run), .tick(tick), .preset(pickup4_r), .done(tmr4Done)
	);
	pickup_timer #(.TW(TW)) u_rst1 (
		.mclk(mclk), .rst(rst), .run(rst1Run), .tick(tick), .preset(reset1_r), .done(rst1Done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// trip sequence

	// state advance; leaving outer aborts any step before the trip
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (tmr1Done) begin
					state_nxt = ST_LATCH1;
				end
			end
			ST_LATCH1: begin
				if (!outer) begin
					state_nxt = ST_IDLE;
				end else if (tmr2Done) begin
					state_nxt = ST_LATCH2;
				end else if (tmr3Done) begin
					state_nxt = ST_ARMED;
				end
			end
			ST_LATCH2: begin
				if (!outer) begin
					state_nxt = ST_IDLE;
				end else if (tmr3Done) begin
					state_nxt = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (!outer) begin
					state_nxt = ST_IDLE;
				end else if (tmr4Done) begin
					state_nxt = ST_LATCH4;
				end
			end
			ST_LATCH4: begin
				if (!outer) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// sequence register, cleared while disabled
	always_ff @(posedge mclk) begin
		if (seqClr) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// early trip at arming, delayed trip on the outer exit from latch four
	assign tripEvent = (!tripDelayed && tmr3Done) ||
		(tripDelayed && state_r == ST_LATCH4 && !outer);
	assign incomingEvent = tmr3Done;
	// an armed or latched-four swing leaving outer is an unstable outgoing one
	assign outgoingEvent = !seqClr && !outer &&
		(state_r == ST_ARMED || state_r == ST_LATCH4);

	////////////////////////////////////////////////////////////////////////////////
	// trip seal-in

	// the block input only cuts the output; the sequence above ignores it
	always_ff @(posedge mclk) begin
		if (seqClr || trip_block_input) begin
			sealCnt_r  <= '0;
			sealLive_r <= 1'b0;
		end else if (tripEvent) begin
			sealCnt_r  <= trip_sealin_time;
			sealLive_r <= 1'b1;
		end else if (tick && sealLive_r) begin
			sealCnt_r  <= sealCnt_r - 1'b1;
			sealLive_r <= sealCnt_r > TW'(1);
		end
	end

	// the delayed trip is a one-cycle event, so the seal-in is what holds it
	always_ff @(posedge mclk) begin
		if (seqClr) begin
			tripOut <= 1'b0;
		end else begin
			tripOut <= (tripEvent || sealLive_r) && !trip_block_input;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// swing blocking

	// set by the first timer, dropped by the reset timer after outer exit or at once while disabled
	always_ff @(posedge mclk) begin
		if (seqClr) begin
			blockLatch_r <= 1'b0;
		end else if (tmr1Done) begin
			blockLatch_r <= 1'b1;
		end else if (rst1Done) begin
			blockLatch_r <= 1'b0;
		end
	end

	// remembers a disturbance seen after blocking was already established
	always_ff @(posedge mclk) begin
		if (seqClr || !blockLatch_r) begin
			faultSeen_r <= 1'b0;
		end else if (disturbRaw) begin
			faultSeen_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs

	// every flag below is cleared at once while disabled
	always_ff @(posedge mclk) begin
		if (seqClr) begin
			outerZone              <= 1'b0;
			middleZone             <= 1'b0;
			innerZone              <= 1'b0;
			timer2_pickup_flag     <= 1'b0;
			timer3_pickup_flag     <= 1'b0;
			timer4_pickup_flag     <= 1'b0;
			swingBlockOut          <= 1'b0;
			swing_unblockable_out  <= 1'b0;
			disturbance_detect_out <= 1'b0;
			incomingOut            <= 1'b0;
			outgoingOut            <= 1'b0;
		end else begin
			outerZone              <= outer;
			middleZone             <= middle;
			innerZone              <= inner;
			timer2_pickup_flag     <= tmr2Run;
			timer3_pickup_flag     <= tmr3Run;
			timer4_pickup_flag     <= tmr4Run;
			swingBlockOut          <= blockLatch_r;
			// a fault in this very cycle also drops it
			swing_unblockable_out  <= blockLatch_r && !faultSeen_r && !disturbRaw;
			disturbance_detect_out <= disturbRaw;
			incomingOut            <= incomingEvent;
			outgoingOut            <= outgoingEvent;
		end
	end
endmodule : out_of_step_trip_sequencer
`default_nettype wire

// ---- design/pickup_timer.sv ----
// pickup timer: counts ticks while its condition holds, clears when it drops
// assumes tick is a one-cycle pulse on the same clock
`timescale 1ns/100ps
`default_nettype none
module pickup_timer #(
	parameter int TW = 16
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          run,
	input  wire logic          tick,
	input  wire logic [TW-1:0] preset,
	output logic               done
);
	logic [TW-1:0] cnt_r; // elapsed ticks, saturates at preset

	// count while running; dropping the condition restarts the interval
	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			cnt_r <= '0;
		end else if (tick && cnt_r < preset) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// done only while still running, so a stale count never fires
	assign done = run && (cnt_r >= preset);
endmodule : pickup_timer
`default_nettype wire

// ---- design/zone_qualifier.sv ----
// forms zone membership from lens and rectangular comparators, blinders and supervision
// assumes all comparator flags are produced on mclk by the impedance logic
`timescale 1ns/100ps
`default_nettype none
module zone_qualifier
	import oos_seq_pkg::*;
#(
	parameter int NZ = 3
) (
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               enable,
	input  wire logic               lensShape,
	input  wire logic [TIMER_W-1:0] posSeqCurrent,
	input  wire logic [TIMER_W-1:0] current_supervision_level,
	input  wire logic [NZ-1:0]      lensZone,
	input  wire logic [NZ-1:0]      rectZone,
	input  wire logic [NZ-1:0]      rightBlinder,
	input  wire logic [NZ-1:0]      leftBlinder,
	output logic [NZ-1:0]           zone
);
	logic supvOk; // one current level qualifies every zone

	assign supvOk = posSeqCurrent >= current_supervision_level;

	genvar z;
	generate
		for (z = 0; z < NZ; z++) begin : g_zone
			logic raw; // unregistered membership of this zone
			// lens uses blinders and drops the rect reaches entirely
			assign raw = lensShape ?
				(lensZone[z] && rightBlinder[z] && leftBlinder[z]) :
				rectZone[z];
			// one sample per clock, cleared while disabled
			always_ff @(posedge mclk) begin
				if (rst || !enable) begin
					zone[z] <= 1'b0;
				end else begin
					zone[z] <= raw && supvOk;
				end
			end
		end
	endgenerate
endmodule : zone_qualifier
`default_nettype wire

// ---- testbench/oos_seq_chk.sv ----
// concurrent checks on the ports of the out-of-step trip sequencer
// assumes one clock mclk and a synchronous active-high rst
`timescale 1ns/100ps
`default_nettype none
module oos_seq_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic trip_block_input,
	input wire logic outerZone,
	input wire logic middleZone,
	input wire logic innerZone,
	input wire logic timer2_pickup_flag,
	input wire logic timer3_pickup_flag,
	input wire logic timer4_pickup_flag,
	input wire logic swingBlockOut,
	input wire logic swing_unblockable_out,
	input wire logic disturbance_detect_out,
	input wire logic incomingOut,
	input wire logic outgoingOut,
	input wire logic tripOut
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	// blocking outputs
	property p_unblk_sub; swing_unblockable_out |-> swingBlockOut; endproperty
	a_unblk_sub: assert property (p_unblk_sub) else $error("unblockable without block");
	property p_unblk_drop;
		$rose(disturbance_detect_out) && $past(swingBlockOut) |-> !swing_unblockable_out;
	endproperty
	a_unblk_drop: assert property (p_unblk_drop) else $error("unblockable kept on fault");
	property p_block_fall; $fell(swingBlockOut) |-> !outerZone; endproperty
	a_block_fall: assert property (p_block_fall) else $error("block dropped inside outer");
	////////////////////////////////////////////////////////////////////////////////
	// trip and swing direction pulses
	property p_trip_gate; trip_block_input |=> !tripOut; endproperty
	a_trip_gate: assert property (p_trip_gate) else $error("trip while blocked");
	property p_trip_cause; $rose(tripOut) |-> incomingOut || outgoingOut; endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip without arming event");
	property p_inc_pulse; incomingOut |=> !incomingOut; endproperty
	a_inc_pulse: assert property (p_inc_pulse) else $error("incoming longer than a cycle");
	property p_outgoing; outgoingOut |-> !outerZone; endproperty
	a_outgoing: assert property (p_outgoing) else $error("outgoing inside outer");
	////////////////////////////////////////////////////////////////////////////////
	// timer pickup flags follow their zone conditions, then the reset check and covers
	property p_t2; timer2_pickup_flag |-> middleZone && !innerZone; endproperty
	a_t2: assert property (p_t2) else $error("timer two outside band");
	property p_t3; timer3_pickup_flag |-> innerZone; endproperty
	a_t3: assert property (p_t3) else $error("timer three outside inner");
	property p_t4; timer4_pickup_flag |-> outerZone && !innerZone; endproperty
	a_t4: assert property (p_t4) else $error("timer four outside band");
	property p_rst; $past(rst) |-> !tripOut && !swingBlockOut && !outerZone; endproperty
	a_rst: assert property (p_rst) else $error("outputs set after reset");
	c_early: cover property (incomingOut && tripOut);
	c_delayed: cover property (outgoingOut && tripOut);
	c_unblk: cover property ($fell(swing_unblockable_out) && swingBlockOut);
endmodule : oos_seq_chk
`default_nettype wire

// ---- testbench/tb_out_of_step_trip_sequencer.sv ----
// self-checking bench: register port plus swing sequences through a zone model
// assumes timer tick shortened to 4 cycles and all delays set to 2 ticks except seal-in at 3
`timescale 1ns/100ps
`default_nettype none
module tb_out_of_step_trip_sequencer;
	import oos_seq_pkg::*;
	localparam int TK = 4; // short tick keeps the run brief
	localparam int OZ = 0, T2 = 1, T4 = 2, BLK = 3, UBK = 4, DD = 5, INC = 6, OUT = 7, TRP = 8;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0;
	logic [DATA_W-1:0] rdv;
	logic regWr = 1'b0, regRd = 1'b0, disturbRaw = 1'b0, trip_block_input = 1'b0, lens = 1'b0;
	logic [TIMER_W-1:0] posSeqCurrent = 16'h0100;
	logic [1:0] depth = 2'h0;
	wire logic [DATA_W-1:0] regRdata;
	wire logic [2:0] lensZone, rectZone, rightBlinder, leftBlinder;
	wire logic outerZone, middleZone, innerZone, timer2_pickup_flag, timer3_pickup_flag;
	wire logic timer4_pickup_flag, swingBlockOut, swing_unblockable_out, disturbance_detect_out;
	wire logic incomingOut, outgoingOut, tripOut;
	wire logic [8:0] obs; // observed outputs, indexed by the names above
	int n_errors = 0, checked = 0, cyc = 0;
	assign obs = {tripOut, outgoingOut, incomingOut, disturbance_detect_out, swing_unblockable_out,
		swingBlockOut, timer4_pickup_flag, timer2_pickup_flag, outerZone};
	always #25 mclk = ~mclk;
	out_of_step_trip_sequencer #(.TICK_CYCLES(TK)) dut (.mclk, .rst, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .posSeqCurrent, .lensZone, .rectZone, .rightBlinder, .leftBlinder,
		.disturbRaw, .trip_block_input, .outerZone, .middleZone, .innerZone, .timer2_pickup_flag,
		.timer3_pickup_flag, .timer4_pickup_flag, .swingBlockOut, .swing_unblockable_out,
		.disturbance_detect_out, .incomingOut, .outgoingOut, .tripOut);
	zone_source_model zsrc (.mclk, .depth, .lens, .lensZone, .rectZone, .rightBlinder, .leftBlinder);
	////////////////////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	// data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 rdv = regRdata;
		chk(rdv, exp);
	endtask : rd
	// bounded wait for one output to reach a level, then compare it
	task automatic await(input int i, input logic v);
		int k;
		k = 0;
		while (obs[i] !== v && k < 60) begin
			@(posedge mclk);
			#1 k++;
		end
		chk({31'h0, obs[i]}, {31'h0, v});
	endtask : await
	task automatic mv(input logic [1:0] d);
		@(posedge mclk);
		depth <= d;
	endtask : mv
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			print_verdict;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rd(REG_CTRL, 32'h0);
		rd(REG_PICKUP1, 32'h1);
		rd(8'h24, 32'h0);
		wr(REG_STATUS, 32'hFFF);
		rd(REG_STATUS, 32'h80);
		for (int a = 4; a < 28; a += 4)
			wr(8'(a), 32'h2);
		wr(REG_SEALIN, 32'h3);
		rd(REG_SEALIN, 32'h3);
		$display("test registers done");
		// three-step, early trip, rectangular zones
		wr(REG_CTRL, 32'h3);
		mv(2'h1);
		await(BLK, 1'b1);
		rd(REG_STATUS, {20'h0, 5'h02, 3'h1, 4'hC});
		mv(2'h2);
		await(T2, 1'b1);
		// latch two ends the second stage, so its pickup flag drops
		await(T2, 1'b0);
		mv(2'h3);
		await(INC, 1'b1);
		chk({29'h0, innerZone, middleZone, timer3_pickup_flag}, 32'h7);
		chk({31'h0, tripOut}, 32'h1);
		repeat (8) @(posedge mclk);
		#1 chk({31'h0, tripOut}, 32'h1);
		await(TRP, 1'b0);
		mv(2'h0);
		await(OUT, 1'b1);
		await(BLK, 1'b0);
		$display("test early trip done");
		// two-step, delayed trip, lens zones: middle never entered alone
		lens <= 1'b1;
		wr(REG_CTRL, 32'hD);
		mv(2'h1);
		await(BLK, 1'b1);
		mv(2'h3);
		await(INC, 1'b1);
		chk({31'h0, tripOut}, 32'h0);
		mv(2'h1);
		await(T4, 1'b1);
		repeat (16) @(posedge mclk);
		#1 chk({31'h0, tripOut}, 32'h0);
		mv(2'h0);
		await(TRP, 1'b1);
		await(BLK, 1'b0);
		$display("test delayed trip done");
		// block input and a fault during the swing
		@(posedge mclk) lens <= 1'b0;
		trip_block_input <= 1'b1;
		wr(REG_CTRL, 32'h3);
		mv(2'h1);
		await(BLK, 1'b1);
		chk({31'h0, swing_unblockable_out}, 32'h1);
		@(posedge mclk) disturbRaw <= 1'b1;
		await(DD, 1'b1);
		chk({31'h0, swing_unblockable_out}, 32'h0);
		@(posedge mclk) disturbRaw <= 1'b0;
		mv(2'h2);
		await(T2, 1'b1);
		await(T2, 1'b0);
		mv(2'h3);
		await(INC, 1'b1);
		chk({31'h0, tripOut}, 32'h0);
		mv(2'h0);
		trip_block_input <= 1'b0;
		await(BLK, 1'b0);
		$display("test trip block done");
		// current supervision, then disable
		wr(REG_SUPV, 32'h200);
		mv(2'h1);
		repeat (4) @(posedge mclk);
		#1 chk({31'h0, outerZone}, 32'h0);
		wr(REG_SUPV, 32'h100);
		await(OZ, 1'b1);
		wr(REG_CTRL, 32'h0);
		await(OZ, 1'b0);
		chk({31'h0, swingBlockOut}, 32'h0);
		$display("test supervision done");
		print_verdict;
	end
endmodule : tb_out_of_step_trip_sequencer
bind out_of_step_trip_sequencer oos_seq_chk chk (.mclk, .rst, .trip_block_input, .outerZone,
	.middleZone, .innerZone, .timer2_pickup_flag, .timer3_pickup_flag, .timer4_pickup_flag,
	.swingBlockOut, .swing_unblockable_out, .disturbance_detect_out, .incomingOut, .outgoingOut,
	.tripOut);
`default_nettype wire

// ---- testbench/zone_source_model.sv ----
// impedance comparator model: turns a locus depth into zone flags
// assumes depth 0 outside, 1 outer only, 2 middle, 3 inner; zones nest
`timescale 1ns/100ps
`default_nettype none
module zone_source_model (
	input  wire logic       mclk,
	input  wire logic [1:0] depth,
	input  wire logic       lens,
	output logic [2:0]      lensZone,
	output logic [2:0]      rectZone,
	output logic [2:0]      rightBlinder,
	output logic [2:0]      leftBlinder
);
	logic [2:0] nest; // nested membership, outer widest
	always_comb nest = 3'h7 >> (2'h3 - depth);
	// the family not selected shows the inverse, so a wrong pick is seen
	always_ff @(posedge mclk) begin
		lensZone <= lens ? nest : ~nest;
		rectZone <= lens ? ~nest : nest;
		rightBlinder <= lens ? 3'h7 : ~nest;
		leftBlinder <= lens ? 3'h7 : ~nest;
	end
endmodule : zone_source_model
`default_nettype wire
